// ### src/adcsel_pkg.sv
// Constants, types and helpers shared by the input-select and result logic.
package adcsel_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_RES_LOW  = 10'h078;
  localparam logic [9:0] IDX_RES_HIGH = 10'h079;
  localparam logic [9:0] IDX_CTRL     = 10'h07a;
  localparam logic [9:0] IDX_SEL      = 10'h07c;
  localparam logic [9:0] IDX_MASK     = 10'h07d;
  localparam int ADDR_W = 12;
  // Field positions of the input-selection register.
  localparam int REF_HI   = 7;
  localparam int REF_LO   = 6;
  localparam int LADJ_BIT = 5;
  localparam int CHAN_HI  = 4;
  // Field positions of the control/status and mask registers.
  localparam int START_BIT = 6;
  localparam int DONE_BIT  = 4;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Reference select encodings.
  localparam logic [1:0] REF_EXT    = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INT    = 2'h3;
  // Channel codes with fixed meaning.
  localparam logic [4:0] CH_DIFF_LAST = 5'h1d;
  localparam logic [4:0] CH_BANDGAP   = 5'h1e;
  localparam logic [4:0] CH_GROUND    = 5'h1f;
  // Result code limits.
  localparam logic [9:0] SE_MAX   = 10'h3ff;
  localparam logic [9:0] DIFF_MAX = 10'h1ff;
  localparam logic [9:0] DIFF_MIN = 10'h200;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic {CV_IDLE, CV_BUSY} adcsel_conv_e;

  // True for the channel codes that select a differential pair.
  function automatic logic adcsel_is_diff(input logic [4:0] ch);
    return ch[4] && (ch <= CH_DIFF_LAST);
  endfunction
endpackage

// ### src/adcsel_sel_if.sv
// Interface carrying buffered and working selections between modules.
`timescale 1ns/1ps
`default_nettype none
interface adcsel_sel_if;
  logic [1:0] buf_ref;
  logic [4:0] buf_chan;
  logic       busy;
  logic       last_cycle;
  logic [2:0] pos_sel;
  logic       neg_sel;
  logic       diff;
  logic       bandgap;
  logic       ground;
  logic       mux_en;
  logic       ref_ext;
  logic       ref_supply;
  logic       ref_int;
  modport owner (input buf_ref, buf_chan, busy, last_cycle,
                 output pos_sel, neg_sel, diff, bandgap, ground, mux_en,
                 output ref_ext, ref_supply, ref_int);
  modport user (output buf_ref, buf_chan, busy, last_cycle,
                input pos_sel, neg_sel, diff, bandgap, ground, mux_en,
                input ref_ext, ref_supply, ref_int);
endinterface
`default_nettype wire

// ### src/adcsel_mux_buf.sv
// Working copy of reference and channel selection with routing decode.
`timescale 1ns/1ps
`default_nettype none
module adcsel_mux_buf
  import adcsel_pkg::*;
(
  input wire logic  aclk,
  input wire logic  aresetn,
  adcsel_sel_if.owner sel
);
  logic [1:0] work_ref;
  logic [4:0] work_chan;

  // All checks below sample on the block clock and pause in reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // freeze working copy
  // Copies the buffer while idle and in the last core cycle only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_ref  <= SEL_RESET[REF_HI:REF_LO];
      work_chan <= SEL_RESET[CHAN_HI:0];
    end else if (!sel.busy || sel.last_cycle) begin
      work_ref  <= sel.buf_ref;
      work_chan <= sel.buf_chan;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel.pos_sel <= 3'h0;
      sel.neg_sel <= 1'b0;
      sel.diff    <= 1'b0;
      sel.bandgap <= 1'b0;
      sel.ground  <= 1'b0;
      sel.mux_en  <= 1'b0;
    end else begin
      sel.pos_sel <= work_chan[2:0];
      sel.neg_sel <= work_chan[3];
      sel.diff    <= adcsel_is_diff(work_chan);
      sel.bandgap <= (work_chan == CH_BANDGAP);
      sel.ground  <= (work_chan == CH_GROUND);
      sel.mux_en  <= (work_chan[4:3] != 2'h1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel.ref_ext    <= 1'b0;
      sel.ref_supply <= 1'b0;
      sel.ref_int    <= 1'b0;
    end else begin
      sel.ref_ext    <= (work_ref == REF_EXT);
      sel.ref_supply <= (work_ref == REF_SUPPLY);
      sel.ref_int    <= (work_ref == REF_INT);
    end
  end

  hold_sel_a: assert property (
    sel.busy && !sel.last_cycle |=> $stable(work_ref) && $stable(work_chan))
    else $error("Selection changed during a conversion.");
  resume_sel_a: assert property (
    sel.busy && sel.last_cycle |=> work_ref == $past(sel.buf_ref) &&
    work_chan == $past(sel.buf_chan))
    else $error("Selection not copied in the last cycle.");
  route_bg_a: assert property (
    work_chan == CH_BANDGAP |=> sel.bandgap && !sel.diff && !sel.ground)
    else $error("Bandgap code not routed as single-ended.");
  ref_rsvd_a: assert property (
    work_ref == 2'h2 |=> !sel.ref_ext && !sel.ref_supply && !sel.ref_int)
    else $error("Reserved reference code enabled a source.");
  ch_unused_a: assert property (
    work_chan[4:3] == 2'h1 |=> !sel.mux_en)
    else $error("Unused channel code connected an input.");
endmodule
`default_nettype wire

// ### src/adcsel_top.sv
// Input selection, result formatting and AXI4-Lite registers of the converter.
`timescale 1ns/1ps
`default_nettype none
module adcsel_top
  import adcsel_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    irq,
  output logic                    conv_start,
  input  wire logic               core_last_cycle,
  input  wire logic               core_done,
  input  wire logic signed [11:0] core_value,
  output logic [2:0]              mux_pos_sel,
  output logic                    mux_neg_sel,
  output logic                    mux_diff,
  output logic                    mux_bandgap,
  output logic                    mux_ground,
  output logic                    mux_enable,
  output logic                    ref_ext_en,
  output logic                    ref_supply_en,
  output logic                    ref_int_en
);
  adcsel_sel_if sel_if ();

  logic [7:0]        sel_reg;
  logic [9:0]        res_q;
  logic              res_lock;
  logic              done_flag;
  logic              done_mask;
  logic              conv_diff;
  adcsel_conv_e      conv_state;
  logic              aw_got;
  logic              w_got;
  logic [9:0]        aw_idx;
  logic [7:0]        wbyte;
  logic              wlane0;
  logic              aw_hs;
  logic              w_hs;
  logic              b_hs;
  logic              ar_hs;
  logic              r_hs;
  logic              do_write;
  logic              wr_sel;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              rd_low;
  logic              rd_high;
  logic [9:0]        ar_idx;
  logic [9:0]        sat_code;
  logic              start_req;
  logic              wr_hit;

  // All checks below sample on the block clock and pause in reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Result clamped into the code range of the conversion kind.
  function automatic logic [9:0] clamp_code(input logic signed [11:0] v,
                                            input logic diff);
    logic [9:0] c;
    c = v[9:0];
    if (diff) begin
      if (v > $signed({2'h0, DIFF_MAX}))
        c = DIFF_MAX;
      else if (v < -$signed({2'h0, DIFF_MIN}))
        c = DIFF_MIN;
    end else begin
      if (v < 12'sd0)
        c = 10'h000;
      else if (v > $signed({2'h0, SE_MAX}))
        c = SE_MAX;
    end
    return c;
  endfunction

  // byte placement
  // Result split into high and low byte by the adjustment bit.
  function automatic logic [15:0] present(input logic [9:0] r,
                                          input logic ladj);
    return ladj ? {r, 6'h00} : {6'h00, r};
  endfunction

  // Decodes a register index into its read value.
  function automatic logic [7:0] read_mux(input logic [9:0] idx,
                                          input logic [7:0] selv,
                                          input logic [9:0] r,
                                          input logic busy,
                                          input logic dflag,
                                          input logic dmask);
    logic [15:0] p;
    logic [7:0]  v;
    p = present(r, selv[LADJ_BIT]);
    v = 8'h00;
    case (idx)
      IDX_SEL:      v = selv;
      IDX_RES_LOW:  v = p[7:0];
      IDX_RES_HIGH: v = p[15:8];
      IDX_CTRL:     v = 8'(({7'h00, busy} << START_BIT) |
                           ({7'h00, dflag} << DONE_BIT));
      IDX_MASK:     v = 8'({7'h00, dmask} << DONE_BIT);
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    return idx == IDX_SEL || idx == IDX_RES_LOW || idx == IDX_RES_HIGH ||
           idx == IDX_CTRL || idx == IDX_MASK;
  endfunction

  // Handshakes and decoded register writes.
  assign aw_hs    = s_axi_awvalid && s_axi_awready;
  assign w_hs     = s_axi_wvalid && s_axi_wready;
  assign b_hs     = s_axi_bvalid && s_axi_bready;
  assign ar_hs    = s_axi_arvalid && s_axi_arready;
  assign r_hs     = s_axi_rvalid && s_axi_rready;
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit   = do_write && wlane0;
  assign wr_sel   = wr_hit && (aw_idx == IDX_SEL);
  assign wr_ctrl  = wr_hit && (aw_idx == IDX_CTRL);
  assign wr_mask  = wr_hit && (aw_idx == IDX_MASK);
  assign ar_idx   = s_axi_araddr[ADDR_W-1:2];
  assign rd_low   = ar_hs && (ar_idx == IDX_RES_LOW);
  assign rd_high  = ar_hs && (ar_idx == IDX_RES_HIGH);
  assign sat_code = clamp_code(core_value, conv_diff);
  assign start_req = wr_ctrl && wbyte[START_BIT] &&
                     (conv_state == CV_IDLE);

  // Write address and data are taken in either order and held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_idx <= 10'h000;
      wbyte  <= 8'h00;
      wlane0 <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_got <= 1'b1;
        aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (w_hs) begin
        w_got  <= 1'b1;
        wbyte  <= s_axi_wdata[7:0];
        wlane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // Ready flags and the write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      s_axi_awready <= !aw_got && !aw_hs && !s_axi_bvalid && !do_write;
      s_axi_wready  <= !w_got && !w_hs && !s_axi_bvalid && !do_write;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_idx) ? RESP_OK : RESP_ERR;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; the read value is captured when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, read_mux(ar_idx, sel_reg, res_q,
                         conv_state == CV_BUSY, done_flag, done_mask)};
        s_axi_rresp  <= mapped(ar_idx) ? RESP_OK : RESP_ERR;
      end else if (r_hs) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      sel_reg <= SEL_RESET;
    else if (wr_sel)
      sel_reg <= wbyte;
  end

  // Conversion sequencing; start is ignored while a conversion runs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_state <= CV_IDLE;
      conv_start <= 1'b0;
      conv_diff  <= 1'b0;
    end else begin
      conv_start <= start_req;
      case (conv_state)
        CV_IDLE: begin
          if (start_req) begin
            conv_state <= CV_BUSY;
            conv_diff  <= adcsel_is_diff(sel_reg[CHAN_HI:0]);
          end
        end
        CV_BUSY: begin
          if (core_done)
            conv_state <= CV_IDLE;
        end
        default: conv_state <= CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      res_lock <= 1'b0;
    else if (rd_high)
      res_lock <= 1'b0;
    else if (rd_low)
      res_lock <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      res_q <= 10'h000;
    else if (core_done && !res_lock)
      res_q <= sat_code;
  end

  // done flag sets
  // A completion in the clearing cycle wins over the write of one.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      done_flag <= 1'b0;
    else if (core_done)
      done_flag <= 1'b1;
    else if (wr_ctrl && wbyte[DONE_BIT])
      done_flag <= 1'b0;
  end

  // Interrupt mask and the level interrupt output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_mask <= 1'b0;
      irq       <= 1'b0;
    end else begin
      if (wr_mask)
        done_mask <= wbyte[DONE_BIT];
      irq <= done_flag && done_mask;
    end
  end

  // Buffered selection goes to the working copy.
  assign sel_if.buf_ref    = sel_reg[REF_HI:REF_LO];
  assign sel_if.buf_chan   = sel_reg[CHAN_HI:0];
  assign sel_if.busy       = (conv_state == CV_BUSY);
  assign sel_if.last_cycle = core_last_cycle;
  assign mux_pos_sel       = sel_if.pos_sel;
  assign mux_neg_sel       = sel_if.neg_sel;
  assign mux_diff          = sel_if.diff;
  assign mux_bandgap       = sel_if.bandgap;
  assign mux_ground        = sel_if.ground;
  assign mux_enable        = sel_if.mux_en;
  assign ref_ext_en        = sel_if.ref_ext;
  assign ref_supply_en     = sel_if.ref_supply;
  assign ref_int_en        = sel_if.ref_int;

  adcsel_mux_buf i_adcsel_mux_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (sel_if)
  );

  done_set_a: assert property (
    core_done |=> done_flag)
    else $error("Done flag not set after completion.");
  res_upd_a: assert property (
    core_done && !res_lock |=> res_q == $past(sat_code))
    else $error("Result not updated at completion.");
  res_hold_a: assert property (
    res_lock && !rd_high |=> $stable(res_q))
    else $error("Result changed while locked.");
  se_floor_a: assert property (
    core_done && !res_lock && !conv_diff && core_value < 12'sd0
    |=> res_q == 10'h000)
    else $error("Single-ended code below zero.");
  diff_sat_a: assert property (
    core_done && !res_lock && conv_diff && core_value > 12'sd511
    |=> res_q == DIFF_MAX)
    else $error("Differential code not saturated.");
  left_high_a: assert property (
    rd_high && sel_reg[LADJ_BIT] |=> s_axi_rdata[7:0] == $past(res_q[9:2]))
    else $error("Left-adjusted high byte wrong.");
  right_low_a: assert property (
    rd_low && !sel_reg[LADJ_BIT] |=> s_axi_rdata[7:0] == $past(res_q[7:0]))
    else $error("Right-adjusted low byte wrong.");
  sel_rst_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> sel_reg == 8'h00)
    else $error("Selection register not zero after reset.");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_flag && done_mask |=> irq)
    else $error("Interrupt not raised for unmasked done.");
endmodule
`default_nettype wire

// ### test/adcsel_core_model.sv
// Behavioural model of the analog converter core behind the block.
`timescale 1ns/1ps
`default_nettype none
module adcsel_core_model (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               conv_start,
  input  wire logic               slow,
  input  wire logic signed [11:0] value,
  output logic                    core_last_cycle,
  output logic                    core_done,
  output logic signed [11:0]      core_value
);
  logic [5:0] cnt;

  // Counts one conversion down; the last cycle comes just before done.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt             <= 6'h00;
      core_last_cycle <= 1'b0;
      core_done       <= 1'b0;
      core_value      <= 12'sh000;
    end else begin
      if (conv_start)
        cnt <= slow ? 6'h28 : 6'h08;
      else if (cnt != 6'h00)
        cnt <= cnt - 6'h01;
      core_last_cycle <= (cnt == 6'h02);
      core_done       <= (cnt == 6'h01);
      // Outside done the value lines toggle so nothing stale looks valid.
      core_value      <= (cnt == 6'h01) ? value : ~core_value;
    end
  end
endmodule
`default_nettype wire

// ### test/test_adc_input_select_result_format.sv
// Self-checking testbench for the converter select and result block.
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_select_result_format
  import adcsel_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  logic [3:0]        lane = 4'h1;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic              start, last, done, mux_en, ndiff, bg, gnd, neg;
  logic              r_ext, r_sup, r_int;
  logic [2:0]        pos;
  logic signed [11:0] val = '0, cval;
  int                miscompares = 0, compares = 0, cycles = 0;
  logic [7:0]  t_sel [5] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'hfb};
  logic [11:0] t_val [5] = '{12'h5dc, 12'hffb, 12'h258, 12'hd44, 12'hfa3};
  logic [7:0]  t_lo  [5] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hc0};
  logic [7:0]  t_hi  [5] = '{8'h03, 8'h00, 8'h01, 8'h02, 8'he8};

  adcsel_top i_adcsel_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .conv_start(start), .core_last_cycle(last), .core_done(done),
    .core_value(cval), .mux_pos_sel(pos), .mux_neg_sel(neg),
    .mux_diff(ndiff), .mux_bandgap(bg), .mux_ground(gnd),
    .mux_enable(mux_en), .ref_ext_en(r_ext), .ref_supply_en(r_sup),
    .ref_int_en(r_int));

  adcsel_core_model i_adcsel_core_model (.aclk(aclk), .aresetn(aresetn),
    .conv_start(start), .slow(slow), .value(val), .core_last_cycle(last),
    .core_done(done), .core_value(cval));

  // Clock of 50 ns period and a watchdog on the whole run.
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One AXI4-Lite write; address and data are offered together.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= lane;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        fin = 1'b1;
      end
    end
  endtask

  // One AXI4-Lite read compared with the expected byte and response.
  task automatic rd(input logic [9:0] idx, input logic [7:0] ed,
                    input logic [1:0] er);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        check("rdata", rdata, {24'h0, ed});
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        fin = 1'b1;
      end
    end
  endtask

  // Starts a conversion, clearing any earlier done flag in the same write.
  task automatic conv_go(input logic [11:0] v, input logic s);
    val  <= v;
    slow <= s;
    wr(IDX_CTRL, 8'h50, RESP_OK);
  endtask

  task automatic conv_wait();
    int n;
    n = 0;
    cyc(2);
    while (irq !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check("irq", irq, 1);
  endtask

  initial begin
    logic [4:0] c;
    logic       df;
    cyc(6);
    aresetn <= 1'b1;
    cyc(3);
    rd(IDX_SEL, 8'h00, RESP_OK);
    check("reset_route", {r_ext, mux_en, pos}, 5'h18);
    rd(10'h07e, 8'h00, RESP_ERR);
    wr(10'h07e, 8'hff, RESP_ERR);
    // A write with the low lane off is answered but changes nothing.
    lane = 4'h0;
    wr(IDX_SEL, 8'hff, RESP_OK);
    lane = 4'h1;
    rd(IDX_SEL, 8'h00, RESP_OK);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      wr(IDX_SEL, {r[1:0], 6'h00}, RESP_OK);
      cyc(3);
      check("ref", {r_ext, r_sup, r_int}, {r == 0, r == 1, r == 3});
      rd(IDX_SEL, {r[1:0], 6'h00}, RESP_OK);
    end
    $display("test reference done");
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      df = c[4] && (c <= 5'd29);
      wr(IDX_SEL, {3'b000, c}, RESP_OK);
      cyc(3);
      check("mux", {mux_en, ndiff, bg, gnd},
            {c[4:3] != 2'b01, df, c == 5'd30, c == 5'd31});
      if (c < 5'd8 || df) check("pos", pos, c[2:0]);
      if (df) check("neg", neg, c[3]);
    end
    $display("test channel done");
    wr(IDX_MASK, 8'h10, RESP_OK);
    // The internal reference is used only with nothing driving the pin.
    for (int i = 0; i < 5; i++) begin
      wr(IDX_SEL, t_sel[i], RESP_OK);
      conv_go(t_val[i], 1'b0);
      conv_wait();
      rd(IDX_RES_LOW, t_lo[i], RESP_OK);
      rd(IDX_RES_HIGH, t_hi[i], RESP_OK);
    end
    $display("test result codes done");
    wr(IDX_SEL, 8'h00, RESP_OK);
    conv_go(12'h155, 1'b0);
    conv_wait();
    rd(IDX_RES_LOW, 8'h55, RESP_OK);
    conv_go(12'h2aa, 1'b0);
    conv_wait();
    rd(IDX_RES_HIGH, 8'h01, RESP_OK);
    conv_go(12'h0f3, 1'b0);
    conv_wait();
    $display("test lock done");
    conv_go(12'h000, 1'b1);
    rd(IDX_CTRL, 8'h40, RESP_OK);
    wr(IDX_SEL, 8'h63, RESP_OK);
    cyc(4);
    check("frozen", {pos, r_ext, r_sup}, 5'h02);
    rd(IDX_RES_LOW, 8'hc0, RESP_OK);
    rd(IDX_RES_HIGH, 8'h3c, RESP_OK);
    conv_wait();
    cyc(3);
    check("resumed", {pos, r_ext, r_sup}, 5'h0d);
    rd(IDX_CTRL, 8'h10, RESP_OK);
    $display("test deferred select done");
    wr(IDX_MASK, 8'h00, RESP_OK);
    conv_go(12'h010, 1'b0);
    cyc(20);
    check("irq_masked", irq, 0);
    rd(IDX_CTRL, 8'h10, RESP_OK);
    wr(IDX_MASK, 8'h10, RESP_OK);
    cyc(3);
    check("irq_unmasked", irq, 1);
    wr(IDX_CTRL, 8'h10, RESP_OK);
    cyc(3);
    check("irq_cleared", irq, 0);
    rd(IDX_MASK, 8'h10, RESP_OK);
    $display("test interrupt done");
    give_verdict();
  end
endmodule
`default_nettype wire
